// File: sds_pkg.sv
// Package with the constants and types of the slice decode scheduler.
package sds_pkg;
    localparam int unsigned CNT_W = 16;
    localparam int unsigned FILL_W = 24;
    localparam int unsigned BPP_W = 8;
    localparam int unsigned SLC_W = 3;
    localparam int unsigned DATA_W = 32;
    localparam int unsigned FIFO_DEPTH = 16;
    localparam logic [CNT_W-1:0] GROUP_PIX = 16'h0003;
    localparam logic [1:0] CHUNK_PART2 = 2'h2;
    localparam logic [1:0] CHUNK_PART2_LONG = 2'h3;
    localparam logic [1:0] CHUNK_MAX = 2'h3;
    localparam logic [CNT_W-1:0] CNT_RST = 16'h0000;
    localparam logic [FILL_W-1:0] FILL_RST = 24'h000000;

    typedef enum logic [1:0] {
        SDS_IDLE,
        SDS_WAIT,
        SDS_RUN,
        SDS_PAUSE
    } sds_state_t;

    typedef struct packed {
        sds_state_t st;
        logic [CNT_W-1:0] pix;
        logic [CNT_W-1:0] div;
        logic [CNT_W-1:0] dpix;
        logic [1:0] chunks;
        logic part2;
        logic pend;
        logic [FILL_W-1:0] fill;
        logic [FILL_W-1:0] cap;
        logic err;
    } sds_sched_t;
endpackage

// File: sds_scheduler.sv
// Slice decode scheduler with its compressed data FIFO.
//
// Function
// RL1 - Blanking or several slices adapt only timing and storage, never the decoding algorithm.
// RL2 - Without blanking, decoding starts the start latency after the slice's first bit.
// RL3 - Transport sends line bits at the active pixel rate and nothing during blank; the transport model sends one word per clock while ready.
// RL4 - With blanking, one slice, start waits latency plus blank after first bit.
// RL5 - With blanking, storage grows by blank duration times blank-free rate in bits.
// RL6 - Extra start delay is allowed when matching extra buffer is added.
// RL7 - Split schedule: part 1 after latency, part 2 resumes at next chunk.
// RL8 - Part 1 decodes slice width minus latency; part 2 decodes the latency.
// RL9 - Parallel mode decodes continuously at pixel rate divided by slice count.
// RL10 - Parallel part 2 waits for chunk 2; part 1 runs right before it.
// RL11 - Parallel mode adds slice width minus latency times bits per pixel.
// RL12 - Chunk length times bits per pixel above rate buffer size is stored extra.
// RL13 - With blanking in parallel mode, same pixel counts at the active pixel rate.
// RL14 - Latency above slice width: part 1 after leftover past chunk 2, part 2 in chunk 3.
// RL15 - After the start, one group of three pixels leaves the buffer each group time.
// RL16 - Pixel and fullness counters kept; error on overflow or underflow of fullness.

`timescale 1ns/1ps

////////////////////////////////////////////////////////////////////////////////
// Compressed data FIFO with valid and ready on both sides.
module sds_fifo #(
    parameter int unsigned WIDTH = sds_pkg::DATA_W,
    parameter int unsigned DEPTH = sds_pkg::FIFO_DEPTH
) (
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic i_in_valid,
    input wire logic [WIDTH-1:0] i_in_data,
    output logic o_in_ready,
    output logic o_out_valid,
    output logic [WIDTH-1:0] o_out_data,
    input wire logic i_out_ready
);
    localparam int unsigned AW = $clog2(DEPTH);

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [AW-1:0] wp;
        logic [AW-1:0] rp;
        logic [AW:0] cnt;
    } sds_fifo_t;

    sds_fifo_t q_ff;
    sds_fifo_t nxt_q;
    logic push;
    logic pop;

    assign o_in_ready = (q_ff.cnt != (AW+1)'(DEPTH));
    assign o_out_valid = (q_ff.cnt != '0);
    assign o_out_data = q_ff.mem[q_ff.rp];
    assign push = i_in_valid && o_in_ready;
    assign pop = o_out_valid && i_out_ready;

    always_comb begin
        nxt_q = q_ff;
        if (push) begin
            nxt_q.mem[q_ff.wp] = i_in_data;
            nxt_q.wp = (q_ff.wp == AW'(DEPTH - 1)) ? '0 : q_ff.wp + 1'b1;
        end
        if (pop) begin
            nxt_q.rp = (q_ff.rp == AW'(DEPTH - 1)) ? '0 : q_ff.rp + 1'b1;
        end
        if (push && !pop) begin
            nxt_q.cnt = q_ff.cnt + 1'b1;
        end else if (pop && !push) begin
            nxt_q.cnt = q_ff.cnt - 1'b1;
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            q_ff <= '0;
        end else begin
            q_ff <= nxt_q;
        end
    end

    fifo_bound_a: assert property (@(posedge i_clk) disable iff (i_rst)
        q_ff.cnt <= (AW+1)'(DEPTH))
        else $error("FIFO count above depth.");
endmodule

////////////////////////////////////////////////////////////////////////////////
// Scheduler top level.
module sds_scheduler #(
    parameter int unsigned WIDTH = sds_pkg::DATA_W,
    parameter int unsigned DEPTH = sds_pkg::FIFO_DEPTH
) (
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic i_sync_par,
    input wire logic i_blank_en,
    input wire logic [sds_pkg::SLC_W-1:0] i_slices,
    input wire logic [sds_pkg::CNT_W-1:0] i_dec_delay,
    input wire logic [sds_pkg::CNT_W-1:0] i_slice_width,
    input wire logic [sds_pkg::CNT_W-1:0] i_horizontal_blank_interval,
    input wire logic [sds_pkg::CNT_W-1:0] i_extra_delay,
    input wire logic [sds_pkg::BPP_W-1:0] i_bpp,
    input wire logic [sds_pkg::FILL_W-1:0] i_rate_buf_bits,
    input wire logic i_pix_tick,
    input wire logic i_line_start,
    input wire logic i_chunk_start,
    input wire logic i_in_valid,
    input wire logic [WIDTH-1:0] i_in_data,
    input wire logic [sds_pkg::BPP_W-1:0] i_in_bits,
    output logic o_in_ready,
    output logic o_grp_valid,
    output logic [WIDTH-1:0] o_grp_data,
    input wire logic i_grp_ready,
    output logic o_decoding,
    output logic o_part2,
    output logic [sds_pkg::CNT_W-1:0] o_pix_cnt,
    output logic [sds_pkg::FILL_W-1:0] o_fullness,
    output logic [sds_pkg::FILL_W-1:0] o_capacity,
    output logic o_error
);
    sds_pkg::sds_sched_t q_ff;
    sds_pkg::sds_sched_t nxt_q;
    logic fifo_in_ready;
    logic fifo_out_valid;
    logic push;
    logic pop;
    logic [sds_pkg::CNT_W-1:0] start_time;
    logic [sds_pkg::CNT_W-1:0] grp_period;
    logic [sds_pkg::CNT_W-1:0] part1_w;
    logic [1:0] need_chunks;
    logic [sds_pkg::FILL_W-1:0] grp_bits;
    logic [sds_pkg::FILL_W-1:0] cap;
    logic long_delay;

    // Multiplies a pixel count by a small factor, cut to the counter width.
    function automatic logic [sds_pkg::CNT_W-1:0] mul_cnt(
        input logic [sds_pkg::CNT_W-1:0] a,
        input logic [sds_pkg::CNT_W-1:0] b
    );
        logic [2*sds_pkg::CNT_W-1:0] p;
        p = a * b;
        mul_cnt = p[sds_pkg::CNT_W-1:0];
    endfunction

    // Converts a pixel-time count into bits at the given bits per pixel.
    function automatic logic [sds_pkg::FILL_W-1:0] to_bits(
        input logic [sds_pkg::CNT_W-1:0] pix,
        input logic [sds_pkg::BPP_W-1:0] bpp
    );
        logic [sds_pkg::CNT_W+sds_pkg::BPP_W-1:0] p;
        p = pix * bpp;
        to_bits = p[sds_pkg::FILL_W-1:0];
    endfunction

    // Widens a slice count to the counter width.
    function automatic logic [sds_pkg::CNT_W-1:0] slc_ext(
        input logic [sds_pkg::SLC_W-1:0] n
    );
        slc_ext = {{(sds_pkg::CNT_W-sds_pkg::SLC_W){1'b0}}, n};
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Data path.
    sds_fifo #(
        .WIDTH(WIDTH),
        .DEPTH(DEPTH)
    ) u_fifo (
        .i_clk(i_clk),
        .i_rst(i_rst),
        .i_in_valid(i_in_valid),
        .i_in_data(i_in_data),
        .o_in_ready(fifo_in_ready),
        .o_out_valid(fifo_out_valid),
        .o_out_data(o_grp_data),
        .i_out_ready(i_grp_ready && q_ff.pend)
    );

    assign o_in_ready = fifo_in_ready;
    assign push = i_in_valid && fifo_in_ready;
    assign o_grp_valid = q_ff.pend && fifo_out_valid;
    assign pop = o_grp_valid && i_grp_ready;

    ////////////////////////////////////////////////////////////////////////////
    // Schedule figures; the coded stream and its buffer model stay untouched. RL1
    always_comb begin
        long_delay = i_dec_delay > i_slice_width;
        if (i_sync_par) begin
            if (long_delay) begin
                start_time = mul_cnt(slc_ext(i_slices), i_slice_width) + i_dec_delay
                    - i_slice_width; // RL14
            end else begin
                start_time = mul_cnt(slc_ext(i_slices), i_dec_delay); // RL10 RL13
            end
            grp_period = mul_cnt(sds_pkg::GROUP_PIX, slc_ext(i_slices)); // RL9
        end else begin
            if (i_blank_en) begin
                start_time = i_dec_delay + i_horizontal_blank_interval; // RL4
            end else begin
                start_time = i_dec_delay; // RL2 RL7
            end
            grp_period = sds_pkg::GROUP_PIX;
        end
        start_time = start_time + i_extra_delay; // RL6
        part1_w = long_delay ? sds_pkg::CNT_RST : i_slice_width - i_dec_delay; // RL8
        need_chunks = (i_sync_par && long_delay) ? sds_pkg::CHUNK_PART2_LONG
            : sds_pkg::CHUNK_PART2; // RL14
        grp_bits = to_bits(sds_pkg::GROUP_PIX, i_bpp); // RL15
        cap = i_rate_buf_bits + to_bits(i_extra_delay, i_bpp); // RL6
        if (i_blank_en) begin
            cap = cap + to_bits(i_horizontal_blank_interval, i_bpp); // RL5
        end
        if (i_sync_par) begin
            cap = cap + to_bits(part1_w, i_bpp); // RL11
        end else if (to_bits(i_slice_width, i_bpp) > i_rate_buf_bits) begin
            cap = cap + to_bits(i_slice_width, i_bpp) - i_rate_buf_bits; // RL12
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Slice line state machine and buffer fullness.
    always_comb begin
        nxt_q = q_ff;
        nxt_q.cap = cap;
        if (i_chunk_start && q_ff.chunks != sds_pkg::CHUNK_MAX) begin
            nxt_q.chunks = q_ff.chunks + 1'b1;
        end
        case (q_ff.st)
            sds_pkg::SDS_IDLE: begin
                if (i_line_start) begin
                    nxt_q.st = sds_pkg::SDS_WAIT;
                    nxt_q.pix = sds_pkg::CNT_RST;
                    nxt_q.dpix = sds_pkg::CNT_RST;
                    nxt_q.div = sds_pkg::CNT_RST;
                    nxt_q.chunks = 2'h1;
                    nxt_q.part2 = 1'b0;
                end
            end
            sds_pkg::SDS_WAIT: begin
                if (q_ff.pix >= start_time) begin
                    nxt_q.st = sds_pkg::SDS_RUN; // RL2 RL4
                end else if (i_pix_tick) begin
                    nxt_q.pix = q_ff.pix + 1'b1; // RL16
                end
            end
            sds_pkg::SDS_RUN: begin
                if (i_pix_tick) begin
                    nxt_q.pix = q_ff.pix + 1'b1;
                    if (q_ff.div >= grp_period - 1'b1) begin
                        nxt_q.div = sds_pkg::CNT_RST;
                        nxt_q.pend = 1'b1; // RL15
                        if (q_ff.pend) begin
                            nxt_q.err = 1'b1; // RL16
                        end
                    end else begin
                        nxt_q.div = q_ff.div + 1'b1;
                    end
                end
                if (!q_ff.part2 && q_ff.dpix >= part1_w) begin
                    if (q_ff.chunks >= need_chunks) begin
                        nxt_q.part2 = 1'b1; // RL10 RL14
                    end else begin
                        nxt_q.st = sds_pkg::SDS_PAUSE; // RL7
                    end
                end else if (q_ff.dpix >= i_slice_width) begin
                    nxt_q.st = sds_pkg::SDS_IDLE; // RL8
                end
            end
            sds_pkg::SDS_PAUSE: begin
                if (i_pix_tick) begin
                    nxt_q.pix = q_ff.pix + 1'b1;
                end
                if (q_ff.chunks >= need_chunks) begin
                    nxt_q.st = sds_pkg::SDS_RUN; // RL7
                    nxt_q.part2 = 1'b1;
                    nxt_q.div = sds_pkg::CNT_RST;
                end
            end
            default: begin
                nxt_q.st = sds_pkg::SDS_IDLE;
            end
        endcase
        if (pop) begin
            nxt_q.pend = 1'b0;
            nxt_q.dpix = q_ff.dpix + sds_pkg::GROUP_PIX; // RL15
        end
        nxt_q.fill = q_ff.fill + (push ? {{(sds_pkg::FILL_W-sds_pkg::BPP_W){1'b0}}, i_in_bits}
            : sds_pkg::FILL_RST);
        if (pop) begin
            if (nxt_q.fill < grp_bits) begin
                nxt_q.err = 1'b1; // RL16
                nxt_q.fill = sds_pkg::FILL_RST;
            end else begin
                nxt_q.fill = nxt_q.fill - grp_bits;
            end
        end
        if (nxt_q.fill > cap) begin
            nxt_q.err = 1'b1; // RL16
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            q_ff <= '0;
        end else begin
            q_ff <= nxt_q;
        end
    end

    assign o_decoding = (q_ff.st == sds_pkg::SDS_RUN);
    assign o_part2 = q_ff.part2;
    assign o_pix_cnt = q_ff.pix;
    assign o_fullness = q_ff.fill;
    assign o_capacity = q_ff.cap;
    assign o_error = q_ff.err;

    ////////////////////////////////////////////////////////////////////////////
    // Checks on the schedule.
    sequence s_wait_done;
        q_ff.st == sds_pkg::SDS_WAIT && q_ff.pix >= start_time;
    endsequence

    sequence s_group_due;
        q_ff.st == sds_pkg::SDS_RUN && i_pix_tick && q_ff.div >= grp_period - 1'b1;
    endsequence

    start_after_latency_a: assert property (@(posedge i_clk) disable iff (i_rst) // RL2
        s_wait_done |=> q_ff.st == sds_pkg::SDS_RUN)
        else $error("Decode did not start at latency.");

    no_early_group_a: assert property (@(posedge i_clk) disable iff (i_rst) // RL4
        q_ff.st == sds_pkg::SDS_WAIT |-> !o_grp_valid && !q_ff.pend)
        else $error("Group issued before start.");

    group_period_a: assert property (@(posedge i_clk) disable iff (i_rst) // RL9
        s_group_due |=> q_ff.pend && q_ff.div == sds_pkg::CNT_RST)
        else $error("Group time not at period.");

    group_removal_a: assert property (@(posedge i_clk) disable iff (i_rst) // RL15
        pop && !push && q_ff.fill >= grp_bits |=> q_ff.fill == $past(q_ff.fill) - $past(grp_bits))
        else $error("Group bits not removed.");

    part2_gate_a: assert property (@(posedge i_clk) disable iff (i_rst) // RL10
        $rose(q_ff.part2) |-> $past(q_ff.chunks) >= $past(need_chunks))
        else $error("Part 2 before its chunk.");

    part1_width_a: assert property (@(posedge i_clk) disable iff (i_rst) // RL8
        $rose(q_ff.part2) |-> $past(q_ff.dpix) >= $past(part1_w))
        else $error("Part 1 shorter than its width.");

    pause_hold_a: assert property (@(posedge i_clk) disable iff (i_rst) // RL7
        q_ff.st == sds_pkg::SDS_PAUSE && q_ff.chunks < need_chunks
        |=> q_ff.st != sds_pkg::SDS_RUN)
        else $error("Resumed before next chunk.");

    error_sticky_a: assert property (@(posedge i_clk) disable iff (i_rst) // RL16
        o_error |=> o_error)
        else $error("Error flag dropped.");

    overflow_flag_a: assert property (@(posedge i_clk) disable iff (i_rst) // RL16
        q_ff.fill > q_ff.cap |-> o_error)
        else $error("Overflow not flagged.");

    blank_storage_a: assert property (@(posedge i_clk) disable iff (i_rst) // RL5
        i_blank_en ##1 $stable(i_blank_en) |->
        q_ff.cap >= $past(i_rate_buf_bits) + to_bits($past(i_horizontal_blank_interval),
        $past(i_bpp)))
        else $error("Blank storage missing.");
endmodule

// File: sds_xport_model.sv
// Transport model that delivers compressed words to the scheduler.
`timescale 1ns/1ps
module sds_xport_model (
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic i_go,
    input wire logic [7:0] i_count,
    input wire logic [7:0] i_bits,
    input wire logic i_blank,
    input wire logic i_ready,
    output logic o_valid,
    output logic [31:0] o_data,
    output logic [7:0] o_bits
);
    logic [7:0] left_ff;
    logic [31:0] seq_ff;
    logic [7:0] nxt_left;
    always_comb begin
        nxt_left = i_go ? i_count : left_ff - {7'h00, o_valid & i_ready};
    end
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            left_ff <= 8'h00;
            seq_ff <= 32'h0;
            o_valid <= 1'b0;
            o_data <= 32'h0;
            o_bits <= 8'h00;
        end else begin
            left_ff <= nxt_left;
            if (o_valid && !i_ready) begin
                o_valid <= 1'b1;
            end else if (nxt_left != 8'h00 && !i_blank) begin
                o_valid <= 1'b1;
                o_data <= seq_ff + 32'h1;
                o_bits <= i_bits;
                seq_ff <= seq_ff + 32'h1;
            end else begin
                o_valid <= 1'b0;
                o_data <= ~o_data;
                o_bits <= ~o_bits;
            end
        end
    end
endmodule

// File: test_slice_decode_scheduler.sv
// Testbench of the slice decode scheduler.
`timescale 1ns/1ps
module test_slice_decode_scheduler;
    logic i_clk = 1'b0;
    logic i_rst = 1'b1;
    logic i_sync_par = 1'b0, i_blank_en = 1'b0, i_pix_tick = 1'b0, i_grp_ready = 1'b1;
    logic i_line_start = 1'b0, i_chunk_start = 1'b0;
    logic [2:0] i_slices = 3'h1;
    logic [15:0] i_dec_delay = 16'h0001, i_slice_width = 16'h0003, i_extra_delay = 16'h0000;
    logic [15:0] i_horizontal_blank_interval = 16'h0005;
    logic [7:0] i_bpp = 8'h01, i_in_bits, cnt = 8'h00, xbits = 8'h00;
    logic [23:0] i_rate_buf_bits = 24'h000064, o_fullness, o_capacity;
    logic i_in_valid, o_in_ready, o_grp_valid, o_decoding, o_part2, o_error;
    logic [31:0] i_in_data, o_grp_data, exp_d = 32'h0;
    logic [15:0] o_pix_cnt;
    logic go = 1'b0, xblank = 1'b0, stall = 1'b0;
    logic [1:0] tdiv = 2'h0;
    int cyc_n = 0, pops = 0, gap = 0, last_c = 0, miscompares = 0, compares = 0;

    sds_scheduler dut (.i_clk, .i_rst, .i_sync_par, .i_blank_en, .i_slices, .i_dec_delay,
        .i_slice_width, .i_horizontal_blank_interval, .i_extra_delay, .i_bpp,
        .i_rate_buf_bits, .i_pix_tick, .i_line_start, .i_chunk_start, .i_in_valid,
        .i_in_data, .i_in_bits, .o_in_ready, .o_grp_valid, .o_grp_data, .i_grp_ready,
        .o_decoding, .o_part2, .o_pix_cnt, .o_fullness, .o_capacity, .o_error);
    sds_xport_model xport (.i_clk(i_clk), .i_rst(i_rst), .i_go(go), .i_count(cnt),
        .i_bits(xbits), .i_blank(xblank), .i_ready(o_in_ready), .o_valid(i_in_valid),
        .o_data(i_in_data), .o_bits(i_in_bits));

    always #50 i_clk = ~i_clk;

    ////////////////////////////////////////////////////////////////////////////
    task automatic summarize;
        $display("compares %0d miscompares %0d", compares, miscompares);
        if (miscompares == 0 && compares > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
        compares++;
        if (got !== ex) begin
            miscompares++;
            $display("Error %s expected %0h seen %0h", nm, ex, got);
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge i_clk);
        #1;
    endtask

    always @(posedge i_clk) begin
        cyc_n++;
        #1;
        tdiv = tdiv + 2'h1;
        i_pix_tick = (tdiv == 2'h0);
        i_grp_ready = !stall || (cyc_n % 8) == 0;
    end

    // Groups are counted mid-cycle, where the handshake has settled.
    always @(negedge i_clk) begin
        if (o_grp_valid === 1'b1 && i_grp_ready === 1'b1) begin
            pops++;
            gap = cyc_n - last_c;
            last_c = cyc_n;
            exp_d = exp_d + 32'h1;
            chk("group data", exp_d, o_grp_data);
        end
    end

    always @(posedge i_clk) begin
        if (cyc_n >= 40000) begin
            miscompares++;
            summarize();
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    task automatic do_reset;
        i_rst = 1'b1;
        cyc(8);
        i_rst = 1'b0;
        exp_d = 32'h0;
    endtask

    task automatic wait_pops(input int n);
        for (int k = 0; k < 3000 && pops < n; k++) begin
            cyc(1);
        end
    endtask

    task automatic run_line(input logic par, input logic bl, input logic [2:0] n,
            input logic [15:0] dly, input logic [15:0] wid, input logic [15:0] ext,
            input logic [7:0] bpp, input logic [23:0] rb, input logic [15:0] st,
            input logic [23:0] cap, input int need);
        int p1;
        int k;
        p1 = (wid > dly) ? int'(wid - dly) / 3 : 0;
        i_sync_par = par;
        i_blank_en = bl;
        i_slices = n;
        i_dec_delay = dly;
        i_slice_width = wid;
        i_extra_delay = ext;
        i_bpp = bpp;
        i_rate_buf_bits = rb;
        pops = 0;
        xblank = 1'b0;
        cnt = 8'(wid / 16'h0003);
        xbits = 8'h03 * bpp;
        go = 1'b1;
        cyc(1);
        go = 1'b0;
        cyc(20);
        chk("capacity", 32'(cap), 32'(o_capacity));
        chk("fullness", 32'(wid) * 32'(bpp), 32'(o_fullness));
        chk("input ready", 32'(cnt < 8'h10), 32'(o_in_ready));
        i_line_start = 1'b1;
        cyc(1);
        i_line_start = 1'b0;
        for (k = 0; k < 2000 && o_decoding !== 1'b1; k++) begin
            cyc(1);
        end
        chk("start pixel", 32'(st), 32'(o_pix_cnt));
        wait_pops(p1);
        cyc(20);
        for (k = 2; k <= need; k++) begin
            chk("paused", 32'h0, 32'(o_decoding));
            i_chunk_start = 1'b1;
            cyc(1);
            i_chunk_start = 1'b0;
            cyc(k < need ? 20 : 1);
        end
        chk("part two", 32'h1, 32'(o_part2));
        wait_pops(int'(wid / 16'h0003));
        if (!stall) begin
            chk("group period", par ? 32'd12 * 32'(n) : 32'd12, 32'(gap));
        end
        cyc(4);
        chk("line done", 32'h0, 32'(o_decoding));
        chk("fullness end", 32'h0, 32'(o_fullness));
        chk("error", 32'h0, 32'(o_error));
    endtask

    ////////////////////////////////////////////////////////////////////////////
    task automatic t_reset;
        chk("ready", 32'h1, 32'(o_in_ready));
        chk("decoding", 32'h0, 32'(o_decoding));
        chk("fullness", 32'h0, 32'(o_fullness));
    endtask

    task automatic t_split;
        run_line(0, 0, 1, 6, 12, 0, 2, 24'h000064, 16'h0006, 24'h000064, 2);
    endtask

    task automatic t_blank;
        xblank = 1'b1;
        cnt = 8'h01;
        go = 1'b1;
        cyc(1);
        go = 1'b0;
        cyc(8);
        chk("blank fullness", 32'h0, 32'(o_fullness));
        run_line(0, 1, 1, 6, 12, 0, 2, 24'h000064, 16'h000b, 24'h00006e, 2);
    endtask

    task automatic t_extra;
        run_line(0, 0, 1, 6, 12, 3, 2, 24'h000064, 16'h0009, 24'h00006a, 2);
    endtask

    task automatic t_excess;
        run_line(0, 0, 1, 6, 12, 0, 4, 24'h000028, 16'h0006, 24'h000030, 2);
    endtask

    task automatic t_par2;
        run_line(1, 0, 2, 6, 12, 0, 2, 24'h000064, 16'h000c, 24'h000070, 2);
    endtask

    task automatic t_par_blank;
        run_line(1, 1, 2, 6, 12, 0, 2, 24'h000064, 16'h000c, 24'h00007a, 2);
    endtask

    task automatic t_par4;
        run_line(1, 0, 4, 8, 6, 0, 2, 24'h000064, 16'h001a, 24'h000064, 3);
    endtask

    task automatic t_fifo;
        stall = 1'b1;
        run_line(0, 0, 1, 6, 48, 0, 1, 24'h000064, 16'h0006, 24'h000064, 2);
        stall = 1'b0;
    endtask

    task automatic t_err;
        i_sync_par = 1'b0;
        i_blank_en = 1'b0;
        i_slices = 3'h1;
        i_slice_width = 16'h000c;
        i_bpp = 8'h01;
        i_rate_buf_bits = 24'h00000a;
        cyc(3);
        chk("capacity", 32'h0c, 32'(o_capacity));
        cnt = 8'h02;
        xbits = 8'h08;
        go = 1'b1;
        cyc(1);
        go = 1'b0;
        cyc(10);
        chk("overflow", 32'h1, 32'(o_error));
        cyc(10);
        chk("sticky", 32'h1, 32'(o_error));
        do_reset();
        chk("cleared", 32'h0, 32'(o_error));
    endtask

    initial begin
        do_reset();
        t_reset();
        t_split();
        t_blank();
        t_extra();
        t_excess();
        t_par2();
        t_par_blank();
        t_par4();
        t_fifo();
        t_err();
        summarize();
    end
endmodule
